// >>> rtl/tcr_regs.svh
/*
 * Register indices, field positions, reset values and timing
 * constants for the touch channel recalibration and interrupt block.
 * Assumes an APB slave with byte address = 4 * register index.
 */
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

// Register indices (byte address is four times the index)
`define TCR_IDX_RECAL 8'h26
`define TCR_IDX_MASK 8'h27
`define TCR_IDX_RPT 8'h28
`define TCR_IDX_STAT 8'h30
`define TCR_IDX_TIME 8'h31
`define TCR_IDX_REL 8'h32
`define TCR_IDX_BUSY 8'h33
`define TCR_IDX_CAL0 8'h38
`define TCR_IDX_CAL7 8'h3F

// Reset values
`define TCR_RST_RECAL 8'h00
`define TCR_RST_MASK 8'hFF
`define TCR_RST_RPT 8'hFF
`define TCR_RST_REL 8'hFF
`define TCR_RST_RATE 4'h4
`define TCR_RST_HOLD 4'h7

// Field positions in the timing register
`define TCR_RATE_LSB 0
`define TCR_HOLD_LSB 4

// Times in milliseconds
`define TCR_RECAL_MAX_MS 10'd600
`define TCR_STEP_MS 10'd35
`define TCR_MS_PER_S 1000

`endif

// >>> rtl/tcr_pkg.sv
/*
 * Types for the touch channel recalibration and interrupt block.
 * Assumes eight sense inputs and ten-bit calibration results.
 */
package tcr_pkg;

    typedef logic [7:0][9:0] tcr_cnt_arr_t;

    typedef struct packed {
        logic [7:0] recal_request;
        logic [7:0] touch_irq_mask;
        logic [7:0] autorepeat_enable;
        logic [7:0] release_irq_allow;
        logic [3:0] repeat_interval_sel;
        logic [3:0] hold_sel;
        logic [7:0] status;
        logic [7:0] busy;
        logic [7:0] invalid;
        logic [7:0] touch_prev;
        logic [7:0] holding;
        logic [7:0] touch_valid;
        tcr_cnt_arr_t cal_tmr;
        tcr_cnt_arr_t hold_cnt;
        tcr_cnt_arr_t rep_cnt;
        tcr_cnt_arr_t cal_result_value;
        logic [14:0] div_cnt;
        logic tick;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tcr_state_t;

endpackage

// >>> rtl/tcr_ctrl.sv
/*
 * Touch channel recalibration and interrupt control, with an APB
 * register slave. Assumes touch detection and the analog calibration
 * engine run on pclk, so their signals need no synchroniser.
 */
// What this block does
// - Request bit forces analog and digital recalibration.
// - Touch detection blanked while input recalibrates, up to 600ms.
// - Baseline counts flagged invalid during recalibration.
// - Touch during recalibration invalidates that attempt.
// - Successful recalibration stores new ten-bit result.
// - Request bit self-clears after successful recalibration.
// - Request bits B0..B7 map inputs 1..8, reset zero.
// - Per-input enable gates touch and release interrupts.
// - Enable one lets touch interrupt; all reset one.
// - Repeat off: interrupt only on touch and release.
// - Repeat on, short touch: touch and release interrupts.
// - Repeat on, held: interrupts repeat at interval.
// - Repeat enable bits per input, reset all enabled.
// - Repeat interval 35ms steps, 35..560ms, reset 175ms.
// - Touch longer than hold threshold is press-and-hold.
`timescale 1ns/1ps
`include "tcr_regs.svh"

module tcr_ctrl #(
    parameter int CLK_HZ = 25000000,
    parameter int MS_CYCLES = CLK_HZ / `TCR_MS_PER_S
) (
    input wire logic pclk, // APB clock, 25 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [7:0] touch_det, // Raw touch per input
    input wire logic [7:0] afe_cal_done, // Calibration finished pulse
    input wire logic [79:0] afe_cal_code, // Result, 10 bits per input
    output logic [7:0] recal_run, // Recalibration running per input
    output logic [7:0] touch_valid, // Touch after blanking
    output logic irq // Interrupt, active high level
);

    localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

    tcr_pkg::tcr_state_t s_r;
    tcr_pkg::tcr_state_t s_nxt;

    logic [7:0] idx;
    logic setup;
    logic wr_acc;
    logic [7:0] wbyte;
    logic [9:0] hold_ms;
    logic [9:0] rate_ms;
    logic [7:0] ev;
    logic [9:0] code;

    assign idx = {2'h0, paddr[7:2]};
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & s_r.pready;
    assign wbyte = pwdata[7:0];

    always_comb
    begin
        s_nxt = s_r;
        ev = 8'h00;
        code = 10'h000;
        // Hold threshold and repeat interval in ms
        hold_ms = 10'(({6'h00, s_r.hold_sel} + 10'd1)
            * `TCR_STEP_MS);
        rate_ms = 10'(({6'h00, s_r.repeat_interval_sel} + 10'd1)
            * `TCR_STEP_MS);

        // Millisecond enable pulse
        s_nxt.tick = 1'b0;
        if (s_r.div_cnt == MS_LAST)
        begin
            s_nxt.div_cnt = 15'h0000;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.div_cnt = s_r.div_cnt + 15'h0001;
        end

        // Register writes; hardware status sets follow and win, a request clear yields to a write of one
        if (wr_acc)
        begin
            unique case (idx)
                `TCR_IDX_RECAL: s_nxt.recal_request = wbyte;
                `TCR_IDX_MASK: s_nxt.touch_irq_mask = wbyte;
                `TCR_IDX_RPT: s_nxt.autorepeat_enable = wbyte;
                `TCR_IDX_REL: s_nxt.release_irq_allow = wbyte;
                `TCR_IDX_STAT: s_nxt.status = s_r.status & ~wbyte;
                `TCR_IDX_TIME:
                begin
                    s_nxt.repeat_interval_sel = wbyte[`TCR_RATE_LSB +: 4];
                    s_nxt.hold_sel = wbyte[`TCR_HOLD_LSB +: 4];
                end
                default: ;
            endcase
        end

        for (int i = 0; i < 8; i++)
        begin
            code = afe_cal_code[i*10 +: 10];
            // Recalibration sequencing
            if (s_r.busy[i])
            begin
                if (touch_det[i])
                begin
                    s_nxt.invalid[i] = 1'b1;
                end
                if (s_r.tick)
                begin
                    s_nxt.cal_tmr[i] = s_r.cal_tmr[i] + 10'd1;
                end
                if (afe_cal_done[i]
                    || s_r.cal_tmr[i] >= `TCR_RECAL_MAX_MS)
                begin
                    s_nxt.busy[i] = 1'b0;
                    if (afe_cal_done[i] && !s_r.invalid[i] && !touch_det[i])
                    begin
                        s_nxt.cal_result_value[i] = code;
                        // Software setting it again in this cycle wins
                        if (!(wr_acc && idx == `TCR_IDX_RECAL && wbyte[i]))
                        begin
                            s_nxt.recal_request[i] = 1'b0;
                        end
                    end
                    // Otherwise the request stays set and reruns
                end
            end
            else if (s_r.recal_request[i])
            begin
                s_nxt.busy[i] = 1'b1;
                s_nxt.invalid[i] = 1'b0;
                s_nxt.cal_tmr[i] = 10'd0;
            end

            // Touch blanked while recalibrating
            s_nxt.touch_valid[i] = touch_det[i] & ~s_r.busy[i];
            s_nxt.touch_prev[i] = s_r.touch_valid[i];

            if (s_r.touch_valid[i] && !s_r.touch_prev[i])
            begin
                ev[i] = 1'b1;
                s_nxt.hold_cnt[i] = 10'd0;
                s_nxt.rep_cnt[i] = 10'd0;
                s_nxt.holding[i] = 1'b0;
            end
            else if (!s_r.touch_valid[i] && s_r.touch_prev[i])
            begin
                ev[i] = s_r.release_irq_allow[i];
                // Short touch with repeat on still reports release
                s_nxt.holding[i] = 1'b0;
            end
            else if (s_r.touch_valid[i] && s_r.tick)
            begin
                if (!s_r.holding[i])
                begin
                    s_nxt.hold_cnt[i] = s_r.hold_cnt[i] + 10'd1;
                    if (s_r.hold_cnt[i] >= hold_ms)
                    begin
                        s_nxt.holding[i] = 1'b1;
                        s_nxt.rep_cnt[i] = 10'd0;
                    end
                end
                else if (s_r.autorepeat_enable[i])
                begin
                    if (s_r.rep_cnt[i] + 10'd1 >= rate_ms)
                    begin
                        ev[i] = 1'b1;
                        s_nxt.rep_cnt[i] = 10'd0;
                    end
                    else
                    begin
                        s_nxt.rep_cnt[i] = s_r.rep_cnt[i] + 10'd1;
                    end
                end
            end
        end

        // Events set sticky status, winning over a clear
        s_nxt.status = s_nxt.status | ev;
        s_nxt.irq = |(s_nxt.status & s_nxt.touch_irq_mask);

        // APB answer: ready in the access cycle, no wait states
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0000_0000;
        if (setup)
        begin
            if (idx >= `TCR_IDX_CAL0 && idx <= `TCR_IDX_CAL7)
            begin
                s_nxt.prdata[9:0] = s_r.cal_result_value[idx[2:0]];
            end
            else
            begin
                unique case (idx)
                    `TCR_IDX_RECAL: s_nxt.prdata[7:0] = s_r.recal_request;
                    `TCR_IDX_MASK: s_nxt.prdata[7:0] = s_r.touch_irq_mask;
                    `TCR_IDX_RPT: s_nxt.prdata[7:0] = s_r.autorepeat_enable;
                    `TCR_IDX_REL: s_nxt.prdata[7:0] = s_r.release_irq_allow;
                    `TCR_IDX_STAT: s_nxt.prdata[7:0] = s_r.status;
                    `TCR_IDX_BUSY: s_nxt.prdata[7:0] = s_r.busy;
                    `TCR_IDX_TIME:
                    begin
                        s_nxt.prdata[`TCR_RATE_LSB +: 4] =
                            s_r.repeat_interval_sel;
                        s_nxt.prdata[`TCR_HOLD_LSB +: 4] = s_r.hold_sel;
                    end
                    default: s_nxt.pslverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.recal_request <= `TCR_RST_RECAL;
            s_r.touch_irq_mask <= `TCR_RST_MASK;
            s_r.autorepeat_enable <= `TCR_RST_RPT;
            s_r.release_irq_allow <= `TCR_RST_REL;
            s_r.repeat_interval_sel <= `TCR_RST_RATE;
            s_r.hold_sel <= `TCR_RST_HOLD;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign recal_run = s_r.busy;
    assign touch_valid = s_r.touch_valid;
    assign irq = s_r.irq;

endmodule

// >>> verification/tcr_afe_model.sv
/* Behavioural calibration engine for tcr_ctrl.
   Assumes recal_run is a level on pclk. */
`timescale 1ns/1ps
module tcr_afe_model #(
    parameter int DLY = 20,
    parameter logic [9:0] CODE = 10'h2B5
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic [7:0] recal_run, // Requests
    output logic [7:0] afe_cal_done, // Done pulses
    output logic [79:0] afe_cal_code // Results
);
    logic [7:0][5:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt <= '0;
            afe_cal_done <= '0;
        end
        else
            for (int i = 0; i < 8; i++)
            begin
                // Runs a calibration while asked
                afe_cal_done[i] <= recal_run[i] && cnt[i] == 6'(DLY - 1)
                    && !afe_cal_done[i];
                cnt[i] <= (recal_run[i] && !afe_cal_done[i]) ?
                    cnt[i] + 6'h1 : 6'h0;
            end
    // Result only valid with its done pulse
    always_comb
        for (int i = 0; i < 8; i++)
            afe_cal_code[10*i +: 10] = afe_cal_done[i] ?
                (CODE ^ 10'(i)) : ~(CODE ^ 10'(i));
endmodule

// >>> verification/tcr_ctrl_properties.sv
/* Port assertions for tcr_ctrl.
   Bound into every tcr_ctrl instance. */
`timescale 1ns/1ps
module tcr_ctrl_properties #(
    parameter int MS_CYCLES = 25000
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [7:0] touch_det, // Raw touch
    input wire logic [7:0] afe_cal_done, // Cal done
    input wire logic [7:0] recal_run, // Running
    input wire logic [7:0] touch_valid, // Touch
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam int RUN_MAX = 600 * MS_CYCLES + 2;
    localparam int RUN_MIN = 599 * MS_CYCLES;
    logic [31:0] run_cnt_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            run_cnt_r <= '0;
        else
            run_cnt_r <= recal_run[0] ? run_cnt_r + 32'h1 : 32'h0;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer; s_setup |=> s_answer; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_rdzero; !pready |-> prdata == 32'h0; endproperty
    property p_blank;
        (recal_run & $past(recal_run) & touch_valid) == 8'h00;
    endproperty
    property p_rise; $rose(touch_valid[1]) |-> $past(touch_det[1]); endproperty
    property p_end;
        $fell(recal_run[0]) |->
            $past(afe_cal_done[0]) || $past(run_cnt_r) >= RUN_MIN;
    endproperty
    property p_max; run_cnt_r <= RUN_MAX; endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(psel && pwrite, 1) || $past(psel && pwrite, 2);
    endproperty
    a_answer: assert property (p_answer) else $error("no ready");
    a_err: assert property (p_err) else $error("lone error");
    a_rdzero: assert property (p_rdzero) else $error("stale data");
    a_blank: assert property (p_blank) else $error("touch in cal");
    a_rise: assert property (p_rise) else $error("bad touch");
    a_end: assert property (p_end) else $error("early end");
    a_max: assert property (p_max) else $error("cal too long");
    a_irq_fall: assert property (p_irq_fall) else $error("no irq");
endmodule
bind tcr_ctrl tcr_ctrl_properties #(.MS_CYCLES(MS_CYCLES)) i_tcr_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .touch_det(touch_det), .afe_cal_done(afe_cal_done),
    .recal_run(recal_run), .touch_valid(touch_valid), .irq(irq));

// >>> verification/tb_top.sv
/* Self-checking bench for tcr_ctrl over APB.
   Assumes the calibration model answers in 20 cycles. */
`timescale 1ns/1ps
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr, touch_det, afe_cal_done, recal_run, touch_valid;
    logic [31:0] pwdata, prdata, q;
    logic [79:0] afe_cal_code;
    int mismatches, n_compared, cyc;
    tcr_ctrl #(.MS_CYCLES(10)) i_tcr_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .touch_det(touch_det),
        .afe_cal_done(afe_cal_done), .afe_cal_code(afe_cal_code),
        .recal_run(recal_run), .touch_valid(touch_valid), .irq(irq));
    tcr_afe_model i_tcr_afe_model (.pclk(pclk), .presetn(presetn),
        .recal_run(recal_run), .afe_cal_done(afe_cal_done),
        .afe_cal_code(afe_cal_code));
    task automatic stop_test;
        $display("Mismatches %0d, compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic rw(input logic w, input logic [7:0] ix,
        input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix[5:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; touch_det = 8'h00;
        wt(12);
        presetn <= 1'b1;
        rw(0, 8'h26, 0); `CHK(q, 32'h00)
        rw(0, 8'h27, 0); `CHK(q, 32'hFF)
        rw(0, 8'h28, 0); `CHK(q, 32'hFF)
        rw(0, 8'h31, 0); `CHK(q, 32'h74)
        rw(0, 8'h01, 0); `CHK(e, 1'b1)
        rw(1, 8'h26, 8'h81); rw(0, 8'h33, 0); `CHK(q, 32'h81)
        wt(40);
        rw(0, 8'h26, 0); `CHK(q, 32'h00)
        rw(0, 8'h38, 0); `CHK(q, 32'h2B5)
        rw(0, 8'h3F, 0); `CHK(q, 32'h2B2)
        rw(1, 8'h26, 8'h01); wt(3); touch_det <= 8'h01; wt(30);
        `CHK(touch_valid, 8'h00)
        rw(0, 8'h26, 0); `CHK(q, 32'h01)
        touch_det <= 8'h00; wt(40);
        rw(0, 8'h26, 0); `CHK(q, 32'h00)
        rw(1, 8'h30, 8'hFF); rw(1, 8'h31, 8'h00);
        touch_det <= 8'h02; wt(5); touch_det <= 8'h00; wt(5);
        `CHK(irq, 1'b1)
        rw(0, 8'h30, 0); `CHK(q, 32'h02)
        rw(1, 8'h30, 8'hFF); wt(2); `CHK(irq, 1'b0)
        rw(1, 8'h27, 8'hFD);
        touch_det <= 8'h02; wt(5); touch_det <= 8'h00; wt(5);
        `CHK(irq, 1'b0)
        rw(1, 8'h27, 8'hFF); wt(2); `CHK(irq, 1'b1)
        rw(1, 8'h30, 8'hFF); touch_det <= 8'h04; wt(800);
        rw(1, 8'h30, 8'hFF); wt(400);
        rw(0, 8'h30, 0); `CHK(q, 32'h04)
        rw(1, 8'h28, 8'h00); rw(1, 8'h30, 8'hFF); wt(400);
        rw(0, 8'h30, 0); `CHK(q, 32'h00)
        touch_det <= 8'h00; wt(5);
        rw(0, 8'h30, 0); `CHK(q, 32'h04)
        stop_test();
    end
endmodule
